// ==== adc_config_calibration_regs.v ====
/*
 Configuration and calibration register bank of a delta-sigma converter, reached
 by byte-wide register read and write commands from the serial port decoder.
 Assumes the port delivers each received byte as a one-cycle strobe on mclk_in,
 that a low frame signal ends any command, and that bytes are at least the
 documented gap apart.
*/
//
// Contract
// - Top bit selects pulse or continuous alignment.
// - Rate field picks 250 to 4000 samples.
// - Bit two picks linear or minimum phase.
// - Chain field selects sinc, low-pass, high-pass stages.
// - Input selector picks one of five connections.
// - Bit three enables amplifier chopping, default on.
// - Gain equals two to the code power.
// - Reduced variant accepts only gains 1, 4, 16.
// - Corner word spans low and high bytes.
// - Corner word resets to 0332h.
// - Offset word in 05h-07h, resets zero.
// - Full-scale word in 08h-0Ah, resets 400000h.
// - First configuration register resets to 52h.
// - Second configuration register resets to 08h.
// - Any write to 01h-0Ah restarts converter, losing 63 results.
// - Two-byte opcode with address and count, gapped.
`timescale 1ns/1ns
`include "adc_cfg_defs.vh"

module adc_config_calibration_regs #(
   parameter REDUCED_GAIN = 0,
   parameter GAP_CYCLES = `BYTE_GAP_CYCLES
) (
   input wire mclk_in,
   input wire rst_n_in,
   input wire frame_in,
   input wire rx_valid_in,
   input wire [7:0] rx_byte_in,
   input wire tx_taken_in,
   input wire result_strobe_in,
   output reg [7:0] tx_byte_out,
   output reg tx_valid_out,
   output reg gap_error_out,
   output reg continuous_align_out,
   output reg [2:0] output_rate_field,
   output reg min_phase_out,
   output reg [1:0] filter_chain_field,
   output reg [2:0] input_select_out,
   output reg amp_modulation_enable,
   output reg [2:0] amp_gain_field,
   output reg [15:0] highpass_corner_word,
   output reg [23:0] offset_cal_word,
   output reg [23:0] fullscale_cal_word,
   output reg converter_restart_out,
   output wire settling_out
);
   localparam ST_OP = 2'd0;
   localparam ST_COUNT = 2'd1;
   localparam ST_WDATA = 2'd2;
   localparam ST_RDATA = 2'd3;

   reg [7:0] rate_filter_config;
   reg [7:0] input_gain_config;
   reg [7:0] highpass_corner_low;
   reg [7:0] highpass_corner_high;
   reg [7:0] offset_cal_low;
   reg [7:0] offset_cal_mid;
   reg [7:0] offset_cal_high;
   reg [7:0] fullscale_cal_low;
   reg [7:0] fullscale_cal_mid;
   reg [7:0] fullscale_cal_high;

   reg [1:0] state;
   reg [4:0] addr;
   reg [4:0] remaining;
   reg is_write;
   reg [5:0] gap_count;
   reg wr_en;
   reg [7:0] wr_data;
   reg [4:0] wr_addr;
   reg [7:0] rd_data;
   reg [2:0] gain_ok;

   // Register read mux; unmapped addresses read zero.
   always @* begin
      rd_data = 8'h00;
      case (addr)
         `ADDR_RATE_FILTER: rd_data = rate_filter_config;
         `ADDR_INPUT_GAIN: rd_data = input_gain_config;
         `ADDR_HP_LOW: rd_data = highpass_corner_low;
         `ADDR_HP_HIGH: rd_data = highpass_corner_high;
         `ADDR_OFS_LOW: rd_data = offset_cal_low;
         `ADDR_OFS_MID: rd_data = offset_cal_mid;
         `ADDR_OFS_HIGH: rd_data = offset_cal_high;
         `ADDR_FS_LOW: rd_data = fullscale_cal_low;
         `ADDR_FS_MID: rd_data = fullscale_cal_mid;
         `ADDR_FS_HIGH: rd_data = fullscale_cal_high;
         default: rd_data = 8'h00;
      endcase
   end

   // Reduced-gain variant keeps the old gain when an unsupported code arrives.
   always @* begin
      gain_ok = wr_data[`GAIN_HI:`GAIN_LO];
      if (REDUCED_GAIN != 0) begin
         if (wr_data[`GAIN_LO] || wr_data[`GAIN_HI:`GAIN_LO] == 3'h6) begin
            gain_ok = input_gain_config[`GAIN_HI:`GAIN_LO];
         end
      end
   end

   // Command sequencer: opcode, count, then data bytes in or out.
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         state <= ST_OP;
         addr <= 5'h00;
         remaining <= 5'h00;
         is_write <= 1'b0;
         gap_count <= 6'h00;
         gap_error_out <= 1'b0;
         wr_en <= 1'b0;
         wr_data <= 8'h00;
         wr_addr <= 5'h00;
         tx_byte_out <= 8'h00;
         tx_valid_out <= 1'b0;
      end else begin
         wr_en <= 1'b0;
         gap_error_out <= 1'b0;
         if (gap_count != 6'h00) begin
            gap_count <= gap_count - 6'h01;
         end
         if (!frame_in) begin
            state <= ST_OP;
            tx_valid_out <= 1'b0;
         end else if (state == ST_RDATA) begin
            if (tx_taken_in || !tx_valid_out) begin
               if (tx_valid_out && remaining == 5'h00) begin
                  tx_valid_out <= 1'b0;
                  state <= ST_OP;
               end else begin
                  if (tx_valid_out) begin
                     addr <= addr + 5'h01;
                     remaining <= remaining - 5'h01;
                  end
                  tx_valid_out <= 1'b0;
               end
            end else begin
               tx_byte_out <= rd_data;
            end
            if (!tx_valid_out && state == ST_RDATA) begin
               tx_byte_out <= rd_data;
               tx_valid_out <= 1'b1;
            end
         end else if (rx_valid_in) begin
            gap_count <= GAP_CYCLES[5:0];
            if (gap_count != 6'h00) begin
               gap_error_out <= 1'b1;
            end
            case (state)
               ST_OP: begin
                  addr <= rx_byte_in[4:0];
                  if (rx_byte_in[7:5] == `OP_WRITE) begin
                     is_write <= 1'b1;
                     state <= ST_COUNT;
                  end else if (rx_byte_in[7:5] == `OP_READ) begin
                     is_write <= 1'b0;
                     state <= ST_COUNT;
                  end
               end
               ST_COUNT: begin
                  remaining <= rx_byte_in[4:0];
                  state <= is_write ? ST_WDATA : ST_RDATA;
               end
               ST_WDATA: begin
                  wr_en <= 1'b1;
                  wr_data <= rx_byte_in;
                  wr_addr <= addr;
                  addr <= addr + 5'h01;
                  remaining <= remaining - 5'h01;
                  if (remaining == 5'h00) begin
                     state <= ST_OP;
                  end
               end
               default: state <= ST_OP;
            endcase
         end
      end
   end

   // Register storage with reset defaults.
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rate_filter_config <= `RST_RATE_FILTER;
         input_gain_config <= `RST_INPUT_GAIN;
         highpass_corner_low <= `RST_HP_LOW;
         highpass_corner_high <= `RST_HP_HIGH;
         offset_cal_low <= `RST_OFS;
         offset_cal_mid <= `RST_OFS;
         offset_cal_high <= `RST_OFS;
         fullscale_cal_low <= `RST_FS_LOW;
         fullscale_cal_mid <= `RST_FS_MID;
         fullscale_cal_high <= `RST_FS_HIGH;
         converter_restart_out <= 1'b0;
      end else begin
         converter_restart_out <= 1'b0;
         if (wr_en && wr_addr >= `ADDR_FIRST && wr_addr <= `ADDR_LAST) begin
            converter_restart_out <= 1'b1;
         end
         if (wr_en) begin
            case (wr_addr)
               `ADDR_RATE_FILTER: rate_filter_config <= wr_data;
               `ADDR_INPUT_GAIN: input_gain_config <= {wr_data[7:3], gain_ok};
               `ADDR_HP_LOW: highpass_corner_low <= wr_data;
               `ADDR_HP_HIGH: highpass_corner_high <= wr_data;
               `ADDR_OFS_LOW: offset_cal_low <= wr_data;
               `ADDR_OFS_MID: offset_cal_mid <= wr_data;
               `ADDR_OFS_HIGH: offset_cal_high <= wr_data;
               `ADDR_FS_LOW: fullscale_cal_low <= wr_data;
               `ADDR_FS_MID: fullscale_cal_mid <= wr_data;
               `ADDR_FS_HIGH: fullscale_cal_high <= wr_data;
               default: ;
            endcase
         end
      end
   end

   // Field outputs registered from the stored bytes, one cycle after the write.
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         continuous_align_out <= 1'b0;
         output_rate_field <= 3'h2;
         min_phase_out <= 1'b0;
         filter_chain_field <= 2'h2;
         input_select_out <= 3'h0;
         amp_modulation_enable <= 1'b1;
         amp_gain_field <= 3'h0;
         highpass_corner_word <= {`RST_HP_HIGH, `RST_HP_LOW};
         offset_cal_word <= {`RST_OFS, `RST_OFS, `RST_OFS};
         fullscale_cal_word <= {`RST_FS_HIGH, `RST_FS_MID, `RST_FS_LOW};
      end else begin
         continuous_align_out <= rate_filter_config[`BIT_ALIGN];
         output_rate_field <= rate_filter_config[`RATE_HI:`RATE_LO];
         min_phase_out <= rate_filter_config[`BIT_PHASE];
         filter_chain_field <= rate_filter_config[`CHAIN_HI:`CHAIN_LO];
         input_select_out <= input_gain_config[`MUX_HI:`MUX_LO];
         amp_modulation_enable <= input_gain_config[`BIT_AMP_MODULATION_ENABLE];
         amp_gain_field <= input_gain_config[`GAIN_HI:`GAIN_LO];
         highpass_corner_word <= {highpass_corner_high, highpass_corner_low};
         offset_cal_word <= {offset_cal_high, offset_cal_mid, offset_cal_low};
         fullscale_cal_word <= {fullscale_cal_high, fullscale_cal_mid, fullscale_cal_low};
      end
   end

   restart_timer #(
      .DISCARD(`RESTART_RESULTS)
   ) u_restart_timer (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .restart_in(converter_restart_out),
      .result_in(result_strobe_in),
      .settling_out(settling_out)
   );
endmodule

// ==== adc_cfg_defs.vh ====
/*
 Constants for the converter's configuration and calibration register bank.
 Assumes it is included by bare name from the bank and its restart timer.
*/
`ifndef ADC_CFG_DEFS_VH
`define ADC_CFG_DEFS_VH

`define ADDR_RATE_FILTER 5'h01
`define ADDR_INPUT_GAIN 5'h02
`define ADDR_HP_LOW 5'h03
`define ADDR_HP_HIGH 5'h04
`define ADDR_OFS_LOW 5'h05
`define ADDR_OFS_MID 5'h06
`define ADDR_OFS_HIGH 5'h07
`define ADDR_FS_LOW 5'h08
`define ADDR_FS_MID 5'h09
`define ADDR_FS_HIGH 5'h0a
`define ADDR_FIRST 5'h01
`define ADDR_LAST 5'h0a

`define RST_RATE_FILTER 8'h52
`define RST_INPUT_GAIN 8'h08
`define RST_HP_LOW 8'h32
`define RST_HP_HIGH 8'h03
`define RST_OFS 8'h00
`define RST_FS_LOW 8'h00
`define RST_FS_MID 8'h00
`define RST_FS_HIGH 8'h40

`define BIT_ALIGN 7
`define RATE_HI 5
`define RATE_LO 3
`define BIT_PHASE 2
`define CHAIN_HI 1
`define CHAIN_LO 0
`define MUX_HI 6
`define MUX_LO 4
`define BIT_AMP_MODULATION_ENABLE 3
`define GAIN_HI 2
`define GAIN_LO 0

`define OP_READ 3'h1
`define OP_WRITE 3'h2

`define BYTE_GAP_CYCLES 24
`define RESTART_RESULTS 63

`endif

// ==== restart_timer.v ====
/*
 Counts the conversion results discarded after a register write.
 Assumes a one-cycle result strobe from the conversion path on the same clock.
*/
`timescale 1ns/1ns
`include "adc_cfg_defs.vh"

module restart_timer #(
   parameter DISCARD = `RESTART_RESULTS
) (
   input wire mclk_in,
   input wire rst_n_in,
   input wire restart_in,
   input wire result_in,
   output reg settling_out
);
   reg [6:0] left;

   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         left <= 7'h00;
         settling_out <= 1'b0;
      end else if (restart_in) begin
         // A fresh write restarts the count even mid-settling.
         left <= DISCARD[6:0];
         settling_out <= 1'b1;
      end else if (result_in && left != 7'h00) begin
         left <= left - 7'h01;
         settling_out <= (left != 7'h01);
      end
   end
endmodule

// ==== adc_cfg_chk.sv ====
/* Port checker for the configuration and calibration register bank.
 Assumes it is bound to the bank and sees only the bank's ports. */
`timescale 1ns/1ns
module adc_cfg_chk (
   input wire mclk_in,
   input wire rst_n_in,
   input wire frame_in,
   input wire rx_valid_in,
   input wire tx_taken_in,
   input wire [7:0] tx_byte_out,
   input wire tx_valid_out,
   input wire continuous_align_out,
   input wire [2:0] output_rate_field,
   input wire min_phase_out,
   input wire [1:0] filter_chain_field,
   input wire [2:0] input_select_out,
   input wire amp_modulation_enable,
   input wire [2:0] amp_gain_field,
   input wire [15:0] highpass_corner_word,
   input wire [23:0] offset_cal_word,
   input wire [23:0] fullscale_cal_word,
   input wire converter_restart_out,
   input wire settling_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   wire [77:0] cfg = {continuous_align_out, output_rate_field, min_phase_out, filter_chain_field, input_select_out,
      amp_modulation_enable, amp_gain_field, highpass_corner_word, offset_cal_word, fullscale_cal_word};
   restart_cause_a: assert property (converter_restart_out |-> $past(rx_valid_in && frame_in, 2))
      else $error("restart without a data byte");
   restart_pulse_a: assert property (converter_restart_out |=> !converter_restart_out)
      else $error("restart pulse too long");
   settle_start_a: assert property (converter_restart_out |=> settling_out)
      else $error("settling not raised");
   settle_cause_a: assert property ($rose(settling_out) |-> $past(converter_restart_out))
      else $error("settling raised without restart");
   tx_hold_a: assert property (tx_valid_out && frame_in && !tx_taken_in |=> tx_valid_out && $stable(tx_byte_out))
      else $error("read byte dropped early");
   tx_drop_a: assert property (tx_valid_out && tx_taken_in |=> !tx_valid_out)
      else $error("read byte held after take");
   field_cause_a: assert property ($changed(cfg) |-> $past(converter_restart_out))
      else $error("field changed without write");
   cfg_reset_a: assert property ($past(!rst_n_in) |-> cfg[77:64] == 14'h0908)
      else $error("config fields not at defaults");
   hp_reset_a: assert property ($past(!rst_n_in) |-> highpass_corner_word == 16'h0332)
      else $error("corner word not at default");
   cal_reset_a: assert property ($past(!rst_n_in) |-> cfg[47:0] == 48'h000000_400000)
      else $error("calibration words not at defaults");
endmodule

// ==== host_model.sv ====
/* Host controller model: sends command bytes and takes read bytes.
 Assumes the bench calls its tasks just after a rising clock edge. */
`timescale 1ns/1ns
module host_model (
   input wire mclk_in,
   input wire tx_valid_in,
   input wire [7:0] tx_byte_in,
   output reg frame_out = 1'b0,
   output reg rx_valid_out = 1'b0,
   output reg [7:0] rx_byte_out = 8'h00,
   output reg tx_taken_out = 1'b0
);
   // Every byte is followed by the minimum gap before the next one.
   task put(input [7:0] b);
      begin
         rx_byte_out = b;
         rx_valid_out = 1'b1;
         @(posedge mclk_in) #1;
         rx_valid_out = 1'b0;
         rx_byte_out = ~b;
         repeat (24) @(posedge mclk_in);
         #1;
      end
   endtask
   // Sends a byte with only a one-cycle gap after it, to provoke the gap flag.
   task rush(input [7:0] b);
      begin
         frame_out = 1'b1;
         rx_byte_out = b;
         rx_valid_out = 1'b1;
         @(posedge mclk_in) #1;
         rx_valid_out = 1'b0;
         rx_byte_out = ~b;
         @(posedge mclk_in) #1;
      end
   endtask
   task cmd(input [2:0] op, input [4:0] a, input integer n);
      begin
         frame_out = 1'b1;
         put({op, a});
         put({3'h0, 5'(n - 1)});
      end
   endtask
   task take(output [7:0] b);
      integer n;
      begin
         for (n = 0; n < 100 && tx_valid_in !== 1'b1; n = n + 1) @(posedge mclk_in) #1;
         b = (tx_valid_in === 1'b1) ? tx_byte_in : 8'hxx;
         tx_taken_out = 1'b1;
         @(posedge mclk_in) #1;
         tx_taken_out = 1'b0;
         repeat (24) @(posedge mclk_in);
         #1;
      end
   endtask
   task close;
      begin
         frame_out = 1'b0;
         @(posedge mclk_in) #1;
      end
   endtask
endmodule

// ==== tb_adc_config_calibration_regs.sv ====
/* Self-checking bench for the register bank, driven by the host model.
 Assumes the bank, its timer, the checker and the host model are compiled. */
`timescale 1ns/1ns
module tb_adc_config_calibration_regs;
   reg mclk_in = 1'b0;
   reg rst_n_in = 1'b0;
   reg result_strobe_in = 1'b0;
   wire frame_in, rx_valid_in, tx_taken_in, tx_valid_out, gap_error_out;
   wire continuous_align_out, min_phase_out, amp_modulation_enable, converter_restart_out, settling_out;
   wire [7:0] rx_byte_in, tx_byte_out;
   wire [2:0] output_rate_field, input_select_out, amp_gain_field;
   wire [1:0] filter_chain_field;
   wire [15:0] highpass_corner_word;
   wire [23:0] offset_cal_word, fullscale_cal_word;
   wire [2:0] reduced_gain;
   integer mismatches = 0, total_checks = 0, restarts = 0, writes = 0, gap_errors = 0, i;
   reg [7:0] exp_reg [0:31];
   reg [7:0] buf_d [0:15];
   reg [7:0] got;
   reg [79:0] pat = 80'hdebc9a123456123446e7;
   always #2 mclk_in = ~mclk_in;
   always @(posedge mclk_in) if (converter_restart_out === 1'b1) restarts = restarts + 1;
   always @(posedge mclk_in) if (gap_error_out === 1'b1) gap_errors = gap_errors + 1;
   host_model host_model_i (.mclk_in(mclk_in), .tx_valid_in(tx_valid_out), .tx_byte_in(tx_byte_out),
      .frame_out(frame_in), .rx_valid_out(rx_valid_in), .rx_byte_out(rx_byte_in), .tx_taken_out(tx_taken_in));
   adc_config_calibration_regs adc_config_calibration_regs_i (.mclk_in, .rst_n_in, .frame_in, .rx_valid_in,
      .rx_byte_in, .tx_taken_in, .result_strobe_in, .tx_byte_out, .tx_valid_out, .gap_error_out,
      .continuous_align_out, .output_rate_field, .min_phase_out, .filter_chain_field, .input_select_out,
      .amp_modulation_enable, .amp_gain_field, .highpass_corner_word, .offset_cal_word, .fullscale_cal_word,
      .converter_restart_out, .settling_out);
   // Second bank built as the reduced-gain variant, fed the same command stream.
   adc_config_calibration_regs #(.REDUCED_GAIN(1)) adc_config_calibration_regs_reduced_i (.mclk_in, .rst_n_in,
      .frame_in, .rx_valid_in, .rx_byte_in, .tx_taken_in, .result_strobe_in, .tx_byte_out(), .tx_valid_out(),
      .gap_error_out(), .continuous_align_out(), .output_rate_field(), .min_phase_out(), .filter_chain_field(),
      .input_select_out(), .amp_modulation_enable(), .amp_gain_field(reduced_gain), .highpass_corner_word(),
      .offset_cal_word(), .fullscale_cal_word(), .converter_restart_out(), .settling_out());
   task chk(input [31:0] s, input [31:0] e);
      begin
         total_checks = total_checks + 1;
         if (s !== e) begin
            mismatches = mismatches + 1;
            $display("ERROR at %0t ns: got %h, expected %h", $time, s, e);
         end
      end
   endtask
   task wr(input [4:0] a, input integer n);
      integer k;
      begin
         host_model_i.cmd(3'h2, a, n);
         for (k = 0; k < n; k = k + 1) begin
            host_model_i.put(buf_d[k]);
            if (a + k >= 1 && a + k <= 10) begin
               exp_reg[a + k] = buf_d[k];
               writes = writes + 1;
            end
         end
         host_model_i.close;
      end
   endtask
   task rd(input [4:0] a, input integer n);
      integer k;
      begin
         host_model_i.cmd(3'h1, a, n);
         for (k = 0; k < n; k = k + 1) begin
            host_model_i.take(got);
            chk(got, exp_reg[a + k]);
         end
         host_model_i.close;
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d, mismatches %0d", total_checks, mismatches);
         if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
         end else begin
            $display("== FAILED ==");
         end
         $finish;
      end
   endtask
   initial begin
      #100000;
      mismatches = mismatches + 1;
      wrap_up;
   end
   initial begin
      for (i = 0; i < 32; i = i + 1) exp_reg[i] = 8'h00;
      exp_reg[1] = 8'h52;
      exp_reg[2] = 8'h08;
      exp_reg[3] = 8'h32;
      exp_reg[4] = 8'h03;
      exp_reg[10] = 8'h40;
      repeat (3) @(posedge mclk_in);
      #1 rst_n_in = 1'b1;
      rd(5'h00, 12);
      // Host keeps the fixed bits and uses only defined field codes.
      for (i = 0; i < 7; i = i + 1) begin
         buf_d[0] = {2'b01, 3'(i % 5), 1'b0, 2'(i % 3 + 1)};
         buf_d[1] = {1'b0, 3'(i % 5), 1'b1, 3'(i)};
         wr(5'h01, 2);
         chk({output_rate_field, filter_chain_field}, {3'(i % 5), 2'(i % 3 + 1)});
         chk({input_select_out, amp_gain_field}, {3'(i % 5), 3'(i)});
         // The reduced variant keeps its previous gain on codes 1, 3, 5 and 6.
         chk(reduced_gain, (i > 4) ? 3'h4 : 3'(i - i % 2));
      end
      for (i = 0; i < 10; i = i + 1) buf_d[i] = pat[8 * i +: 8];
      wr(5'h01, 10);
      chk({continuous_align_out, min_phase_out, amp_modulation_enable}, 3'b110);
      chk(reduced_gain, 3'h4);
      chk(highpass_corner_word, 16'h1234);
      chk(offset_cal_word, 24'h123456);
      chk(fullscale_cal_word, 24'hdebc9a);
      buf_d[0] = 8'h5a;
      wr(5'h0b, 1);
      rd(5'h00, 12);
      chk(restarts, writes);
      chk(gap_errors, 0);
      // Bytes closer than the minimum gap are flagged but still taken.
      host_model_i.rush({3'h2, 5'h05});
      host_model_i.rush(8'h00);
      host_model_i.put(8'ha5);
      host_model_i.close;
      chk(gap_errors, 2);
      chk(offset_cal_word, 24'h1234a5);
      wr(5'h03, 1);
      for (i = 0; i < 63; i = i + 1) begin
         chk(settling_out, 1'b1);
         result_strobe_in = 1'b1;
         @(posedge mclk_in) #1;
         result_strobe_in = 1'b0;
         @(posedge mclk_in) #1;
      end
      repeat (2) @(posedge mclk_in);
      #1;
      chk(settling_out, 1'b0);
      wrap_up;
   end
endmodule
bind adc_config_calibration_regs adc_cfg_chk adc_cfg_chk_i (.mclk_in, .rst_n_in, .frame_in, .rx_valid_in,
   .tx_taken_in, .tx_byte_out, .tx_valid_out, .continuous_align_out, .output_rate_field, .min_phase_out,
   .filter_chain_field, .input_select_out, .amp_modulation_enable, .amp_gain_field, .highpass_corner_word,
   .offset_cal_word, .fullscale_cal_word, .converter_restart_out, .settling_out);
